// file: rtl/acd_top.sv
// Converter back end: register file, correction stage and sample transfer channel
//
// Our own choices: the APB slave port and the address map.
`default_nettype none
module acd_top (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic                             conv_enable,
    output logic                             neg_buffer_select,
    input  wire logic                        conv_done,
    input  wire logic [acd_pkg::DATA_W-1:0]  conv_result,
    output acd_pkg::acd_ram_wr_s             ram_wr,
    input  wire logic                        ram_wr_ready
);
    typedef struct packed {
        logic [15:0]                offset;
        logic [15:0]                gain;
        logic                       conv_en;
        logic                       neg_sel;
        logic [acd_pkg::ADDR_W-1:0] buf_start;
        logic [15:0]                buf_count;
        logic                       wrap;
        acd_pkg::acd_chan_e         chan;
        logic [15:0]                done_cnt;
        logic [acd_pkg::ADDR_W-1:0] cur;
        logic [acd_pkg::FLG_W-1:0]  flags;
        acd_pkg::acd_ram_wr_s       wr;
        logic [31:0]                rdata;
    } acd_state_s;

    acd_state_s            s_q, s_d;
    acd_pkg::acd_sample_s  corr;
    logic                  acc;
    logic                  mapped;
    logic                  wr_acc;
    logic [15:0]           cnt_n;
    logic [acd_pkg::FLG_W-1:0] set;
    logic [acd_pkg::FLG_W-1:0] clr;
    logic [31:0]           rd;

    // Results only pass while the converter is enabled
    acd_corr u_corr (
        .clk    (clk),
        .rstn   (rstn),
        .in_valid(conv_done && s_q.conv_en),
        .in_raw (conv_result),
        .offset (s_q.offset),
        .gain   (s_q.gain),
        .out    (corr)
    );

    always_comb begin
        case (paddr)
            acd_pkg::OFS_OFFSET,
            acd_pkg::OFS_GAIN,
            acd_pkg::OFS_CONV_CFG,
            acd_pkg::OFS_BUF_START,
            acd_pkg::OFS_BUF_COUNT,
            acd_pkg::OFS_CHAN_CFG,
            acd_pkg::OFS_CUR_ADDR,
            acd_pkg::OFS_FLAGS: mapped = 1'b1;
            default:            mapped = 1'b0;
        endcase
        rd = '0;
        case (paddr)
            acd_pkg::OFS_OFFSET:    rd[15:0] = s_q.offset;
            acd_pkg::OFS_GAIN:      rd[15:0] = s_q.gain;
            acd_pkg::OFS_CONV_CFG:  rd[1:0]  = {s_q.neg_sel, s_q.conv_en};
            acd_pkg::OFS_BUF_START: rd       = s_q.buf_start;
            acd_pkg::OFS_BUF_COUNT: rd[15:0] = s_q.buf_count;
            acd_pkg::OFS_CHAN_CFG:  rd[acd_pkg::BIT_WRAP] = s_q.wrap;
            acd_pkg::OFS_CUR_ADDR:  rd       = s_q.cur;
            acd_pkg::OFS_FLAGS:     rd[acd_pkg::FLG_W-1:0] = s_q.flags;
            default:                rd       = '0;
        endcase
    end

    assign acc    = psel && penable;
    assign wr_acc = acc && pwrite && mapped;

    always_comb begin
        s_d   = s_q;
        set   = '0;
        clr   = '0;
        cnt_n = s_q.done_cnt + 16'h0001;
        if (psel && !penable) begin
            s_d.rdata = rd;
        end
        // Sample capture; a busy slot or a stopped linear buffer counts as overrun
        if (corr.valid) begin
            set[acd_pkg::FLG_SAT] = corr.sat;
            if (s_q.chan == acd_pkg::CH_RUN && !s_q.wr.wr_valid) begin
                s_d.wr.wr_valid = 1'b1;
                s_d.wr.wr_addr  = s_q.cur;
                s_d.wr.wr_data  = corr.data;
            end else if (s_q.chan != acd_pkg::CH_IDLE) begin
                set[acd_pkg::FLG_OVR] = 1'b1;
            end
        end
        if (s_q.wr.wr_valid && ram_wr_ready) begin
            s_d.wr.wr_valid = 1'b0;
            if (cnt_n == {1'b0, s_q.buf_count[15:1]}) begin
                set[acd_pkg::FLG_HALF] = 1'b1;
            end
            if (cnt_n == s_q.buf_count) begin
                set[acd_pkg::FLG_FULL] = 1'b1;
                s_d.done_cnt = '0;
                if (s_q.wrap) begin
                    s_d.cur = s_q.buf_start;
                end else begin
                    s_d.chan = acd_pkg::CH_FULL;
                end
            end else begin
                s_d.done_cnt = cnt_n;
                s_d.cur      = s_q.cur + acd_pkg::ADDR_STEP;
            end
        end
        if (wr_acc) begin
            case (paddr)
                acd_pkg::OFS_OFFSET:    s_d.offset = pwdata[15:0];
                acd_pkg::OFS_GAIN:      s_d.gain   = pwdata[15:0];
                acd_pkg::OFS_CONV_CFG: begin
                    // Channel keeps running across configuration changes
                    s_d.conv_en = pwdata[acd_pkg::BIT_CONV_EN];
                    s_d.neg_sel = pwdata[acd_pkg::BIT_NEG_SEL];
                end
                acd_pkg::OFS_BUF_START: s_d.buf_start = {pwdata[31:1], 1'b0};
                acd_pkg::OFS_BUF_COUNT: s_d.buf_count = pwdata[15:0];
                acd_pkg::OFS_CHAN_CFG: begin
                    s_d.wrap = pwdata[acd_pkg::BIT_WRAP];
                    if (pwdata[acd_pkg::BIT_CHAN_RST]) begin
                        s_d.chan        = acd_pkg::CH_IDLE;
                        s_d.wr.wr_valid = 1'b0;
                        s_d.done_cnt    = '0;
                        s_d.cur         = s_q.buf_start;
                    end else if (pwdata[acd_pkg::BIT_LOAD]) begin
                        s_d.chan        = acd_pkg::CH_RUN;
                        s_d.done_cnt    = '0;
                        s_d.cur         = s_q.buf_start;
                    end
                end
                acd_pkg::OFS_FLAGS:     clr = pwdata[acd_pkg::FLG_W-1:0];
                default: ;
            endcase
        end
        // New events win over a clear in the same cycle
        s_d.flags = (s_q.flags & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q        <= '0;
            s_q.offset <= acd_pkg::RST_OFFSET;
            s_q.gain   <= acd_pkg::RST_GAIN;
            s_q.chan   <= acd_pkg::CH_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata            = s_q.rdata;
    assign pready            = 1'b1;
    assign pslverr           = acc && !mapped;
    assign conv_enable       = s_q.conv_en;
    assign neg_buffer_select = s_q.neg_sel;
    assign ram_wr            = s_q.wr;

    property p_reset_vals;
        @(posedge clk) !rstn |=> s_q.gain == acd_pkg::RST_GAIN && s_q.offset == '0;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad offset/gain reset");

    property p_load;
        @(posedge clk) disable iff (!rstn)
            wr_acc && paddr == acd_pkg::OFS_CHAN_CFG && pwdata[acd_pkg::BIT_LOAD]
            && !pwdata[acd_pkg::BIT_CHAN_RST]
            |=> s_q.chan == acd_pkg::CH_RUN && s_q.cur == $past(s_q.buf_start);
    endproperty
    a_load: assert property (p_load) else $error("load did not start channel");

    property p_linear_stop;
        @(posedge clk) disable iff (!rstn)
            s_q.wr.wr_valid && ram_wr_ready && !s_q.wrap && cnt_n == s_q.buf_count && !wr_acc
            |=> s_q.chan == acd_pkg::CH_FULL && s_q.flags[acd_pkg::FLG_FULL];
    endproperty
    a_linear_stop: assert property (p_linear_stop) else $error("linear fill ran on");

    property p_overrun;
        @(posedge clk) disable iff (!rstn)
            s_q.chan == acd_pkg::CH_FULL && corr.valid |=> s_q.flags[acd_pkg::FLG_OVR];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_wrap;
        @(posedge clk) disable iff (!rstn)
            s_q.wr.wr_valid && ram_wr_ready && s_q.wrap && cnt_n == s_q.buf_count && !wr_acc
            |=> s_q.cur == s_q.buf_start && s_q.chan == acd_pkg::CH_RUN;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not return to start");

    property p_half;
        @(posedge clk) disable iff (!rstn)
            s_q.wr.wr_valid && ram_wr_ready && cnt_n == {1'b0, s_q.buf_count[15:1]}
            |=> s_q.flags[acd_pkg::FLG_HALF];
    endproperty
    a_half: assert property (p_half) else $error("half flag missing");

    property p_cur_addr;
        @(posedge clk) disable iff (!rstn)
            s_q.wr.wr_valid |-> s_q.wr.wr_addr == s_q.cur;
    endproperty
    a_cur_addr: assert property (p_cur_addr) else $error("write address not current");

    property p_step;
        @(posedge clk) disable iff (!rstn)
            s_q.wr.wr_valid && ram_wr_ready && cnt_n != s_q.buf_count && !wr_acc
            |=> s_q.cur == $past(s_q.cur) + acd_pkg::ADDR_STEP;
    endproperty
    a_step: assert property (p_step) else $error("address did not step by two");

    property p_stored;
        @(posedge clk) disable iff (!rstn)
            corr.valid && s_q.chan == acd_pkg::CH_RUN && !s_q.wr.wr_valid && !wr_acc
            |=> s_q.wr.wr_valid && s_q.wr.wr_data == $past(corr.data);
    endproperty
    a_stored: assert property (p_stored) else $error("corrected sample not stored");

    property p_sat_flag;
        @(posedge clk) disable iff (!rstn)
            corr.valid && corr.sat |=> s_q.flags[acd_pkg::FLG_SAT];
    endproperty
    a_sat_flag: assert property (p_sat_flag) else $error("saturation not flagged");

    property p_ofs_wr;
        @(posedge clk) disable iff (!rstn)
            wr_acc && paddr == acd_pkg::OFS_OFFSET |=> s_q.offset == $past(pwdata[15:0]);
    endproperty
    a_ofs_wr: assert property (p_ofs_wr) else $error("offset write lost");

    property p_gain_wr;
        @(posedge clk) disable iff (!rstn)
            wr_acc && paddr == acd_pkg::OFS_GAIN |=> s_q.gain == $past(pwdata[15:0]);
    endproperty
    a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");

    // A converter that is off must not feed the channel
    property p_off_drop;
        @(posedge clk) disable iff (!rstn)
            !s_q.conv_en |=> !corr.valid;
    endproperty
    a_off_drop: assert property (p_off_drop) else $error("sample while off");

    property p_cfg_run;
        @(posedge clk) disable iff (!rstn)
            wr_acc && paddr == acd_pkg::OFS_CONV_CFG && !(s_q.wr.wr_valid && ram_wr_ready)
            |=> s_q.chan == $past(s_q.chan);
    endproperty
    a_cfg_run: assert property (p_cfg_run) else $error("config write moved channel");

    property p_wrap_sel;
        @(posedge clk) disable iff (!rstn)
            wr_acc && paddr == acd_pkg::OFS_CHAN_CFG
            |=> s_q.wrap == $past(pwdata[acd_pkg::BIT_WRAP]);
    endproperty
    a_wrap_sel: assert property (p_wrap_sel) else $error("mode bit not taken");

    property p_chan_rst;
        @(posedge clk) disable iff (!rstn)
            wr_acc && paddr == acd_pkg::OFS_CHAN_CFG && pwdata[acd_pkg::BIT_CHAN_RST]
            |=> s_q.chan == acd_pkg::CH_IDLE && !s_q.wr.wr_valid
                && s_q.cur == $past(s_q.buf_start);
    endproperty
    a_chan_rst: assert property (p_chan_rst) else $error("channel reset ignored");

    // Request stays put until the RAM takes it
    property p_wr_hold;
        @(posedge clk) disable iff (!rstn)
            s_q.wr.wr_valid && !ram_wr_ready && !wr_acc
            |=> s_q.wr.wr_valid && $stable(s_q.wr.wr_addr) && $stable(s_q.wr.wr_data);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request dropped");

    property p_idle_quiet;
        @(posedge clk) disable iff (!rstn)
            s_q.chan == acd_pkg::CH_IDLE && !s_q.wr.wr_valid |=> !s_q.wr.wr_valid;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("write before load");

    property p_full_quiet;
        @(posedge clk) disable iff (!rstn)
            s_q.chan == acd_pkg::CH_FULL && !s_q.wr.wr_valid |=> !s_q.wr.wr_valid;
    endproperty
    a_full_quiet: assert property (p_full_quiet) else $error("write after fill");

    property p_count;
        @(posedge clk) disable iff (!rstn)
            s_q.wr.wr_valid && ram_wr_ready && cnt_n != s_q.buf_count && !wr_acc
            |=> s_q.done_cnt == $past(cnt_n);
    endproperty
    a_count: assert property (p_count) else $error("sample count not advanced");

    property p_cur_read;
        @(posedge clk) disable iff (!rstn)
            psel && !penable && paddr == acd_pkg::OFS_CUR_ADDR |=> prdata == $past(s_q.cur);
    endproperty
    a_cur_read: assert property (p_cur_read) else $error("current address misread");
endmodule : acd_top
`default_nettype wire

// file: rtl/acd_pkg.sv
// Constants, types and register map of the converter correction and transfer block
// Operation
// - Add signed offset to each raw 16-bit result first.
// - Multiply offset-corrected value by 16-bit unsigned gain, signed result.
// - Clamp product to 0x7fff or 0x8000 and set saturation flag.
// - Halve the saturated value to give the final sample.
// - Gain is Q1.15: bit 15 integer, bits 14:0 fraction.
// - Reset clears offset and sets gain to 0x8000.
// - Channel stores corrected samples, never raw results.
// - Buffer size counts 16-bit samples.
// - Software resets channel then loads it; load starts the selected mode.
// - Wrap select 0 is linear mode, 1 is auto wrap.
// - Linear mode stops after the programmed count and sets full flag.
// - Sample arriving after linear fill sets the overrun flag.
// - Auto wrap returns pointer to start and keeps writing.
// - Half flag on lower half filled, full flag on upper half filled.
// - Current-address register shows the location being written.
// - Converter runs continuously while its enable bit is set.
// - Configuration writes never halt the running channel; a channel-config write with the reset bit set returns it to idle.
// - Samples are 16 bits, significant bits left-aligned.
`default_nettype none
package acd_pkg;
    localparam int          DATA_W        = 16;
    localparam int          ADDR_W        = 32;
    localparam logic [7:0]  OFS_OFFSET    = 8'h00;
    localparam logic [7:0]  OFS_GAIN      = 8'h04;
    localparam logic [7:0]  OFS_CONV_CFG  = 8'h08;
    localparam logic [7:0]  OFS_BUF_START = 8'h0c;
    localparam logic [7:0]  OFS_BUF_COUNT = 8'h10;
    localparam logic [7:0]  OFS_CHAN_CFG  = 8'h14;
    localparam logic [7:0]  OFS_CUR_ADDR  = 8'h18;
    localparam logic [7:0]  OFS_FLAGS     = 8'h1c;
    localparam logic [15:0] RST_OFFSET    = 16'h0000;
    localparam logic [15:0] RST_GAIN      = 16'h8000;
    localparam int          FRAC_BITS     = 15;
    localparam logic [18:0] SAT_MAX       = 19'h03fff << 1 | 19'h00001;
    localparam logic [18:0] SAT_MIN       = 19'h7c000 << 1;
    localparam logic [15:0] CLIP_MAX      = 16'h7fff;
    localparam logic [15:0] CLIP_MIN      = 16'h8000;
    localparam logic [31:0] ADDR_STEP     = 32'h0000_0002;
    // Conversion config bits
    localparam int          BIT_CONV_EN   = 0;
    localparam int          BIT_NEG_SEL   = 1;
    // Channel config bits
    localparam int          BIT_WRAP      = 0;
    localparam int          BIT_LOAD      = 1;
    localparam int          BIT_CHAN_RST  = 4;
    // Event flag bits
    localparam int          FLG_SAT       = 0;
    localparam int          FLG_HALF      = 1;
    localparam int          FLG_FULL      = 2;
    localparam int          FLG_OVR       = 3;
    localparam int          FLG_W         = 4;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_RUN,
        CH_FULL
    } acd_chan_e;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
        logic              sat;
    } acd_sample_s;

    typedef struct packed {
        logic                    wr_valid;
        logic [ADDR_W-1:0]       wr_addr;
        logic [DATA_W-1:0]       wr_data;
    } acd_ram_wr_s;
endpackage : acd_pkg
`default_nettype wire

// file: rtl/acd_corr.sv
// Offset, gain, saturation and halving of one conversion result
`default_nettype none
module acd_corr (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        in_valid,
    input  wire logic [acd_pkg::DATA_W-1:0]  in_raw,
    input  wire logic [acd_pkg::DATA_W-1:0]  offset,
    input  wire logic [acd_pkg::DATA_W-1:0]  gain,
    output acd_pkg::acd_sample_s             out
);
    acd_pkg::acd_sample_s s_q, s_d;
    logic signed [16:0] sum;
    logic signed [33:0] prod;
    logic signed [18:0] scl;
    logic        [15:0] clip;
    logic               sat;

    always_comb begin
        sum  = $signed({in_raw[15], in_raw}) + $signed({offset[15], offset});
        prod = sum * $signed({1'b0, gain});
        scl  = prod[acd_pkg::FRAC_BITS+18:acd_pkg::FRAC_BITS];
        sat  = 1'b0;
        clip = scl[15:0];
        if (scl > $signed(acd_pkg::SAT_MAX)) begin
            clip = acd_pkg::CLIP_MAX;
            sat  = 1'b1;
        end else if (scl < $signed(acd_pkg::SAT_MIN)) begin
            clip = acd_pkg::CLIP_MIN;
            sat  = 1'b1;
        end
        s_d       = s_q;
        s_d.valid = in_valid;
        if (in_valid) begin
            s_d.data = {clip[15], clip[15:1]};
            s_d.sat  = sat;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign out = s_q;

    property p_corr_latency;
        @(posedge clk) disable iff (!rstn) in_valid |=> out.valid;
    endproperty
    a_corr_latency: assert property (p_corr_latency) else $error("late result");

    property p_corr_clip;
        @(posedge clk) disable iff (!rstn)
            out.valid && out.sat |-> (out.data == 16'h3fff || out.data == 16'hc000);
    endproperty
    a_corr_clip: assert property (p_corr_clip) else $error("bad clamp value");

    property p_corr_unity;
        @(posedge clk) disable iff (!rstn)
            in_valid && gain == acd_pkg::RST_GAIN && offset == '0
            |=> !out.sat && out.data == {$past(in_raw[15]), $past(in_raw[15:1])};
    endproperty
    a_corr_unity: assert property (p_corr_unity) else $error("unity gain not halving");
endmodule : acd_corr
`default_nettype wire

// file: sim/acd_ram_model.sv
// Behavioural system RAM taking halfword writes from the transfer channel
`default_nettype none
module acd_ram_model (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 slow,
    input  wire acd_pkg::acd_ram_wr_s ram_wr,
    output var logic                  ram_wr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [31:0]];
    // Random stalls force the channel to hold its request
    always @(posedge clk) begin
        ram_wr_ready <= !rstn || !slow || ($urandom % 2 == 0);
        if (rstn && ram_wr.wr_valid && ram_wr_ready) begin
            mem[ram_wr.wr_addr] = ram_wr.wr_data;
        end
    end
endmodule : acd_ram_model
`default_nettype wire

// file: sim/acd_tb.sv
// Self-checking bench for the converter back end
`default_nettype none
module acd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk, rstn, psel, penable, pwrite, pready, pslverr, slow;
    logic                 conv_enable, neg_buffer_select, conv_done, ram_wr_ready, err_q;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, rd_q;
    logic [15:0]          conv_result, ofs, gn;
    logic                 sat_exp;
    logic [47:0]          exp_w;
    logic [47:0]          exp_q[$];
    acd_pkg::acd_ram_wr_s ram_wr;
    int                   num_errors, samples_checked, cycles;

    acd_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_enable(conv_enable), .neg_buffer_select(neg_buffer_select),
        .conv_done(conv_done), .conv_result(conv_result), .ram_wr(ram_wr),
        .ram_wr_ready(ram_wr_ready));
    acd_ram_model ram (.clk(clk), .rstn(rstn), .slow(slow), .ram_wr(ram_wr),
        .ram_wr_ready(ram_wr_ready));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_wr(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_wr

    // Called just after a rising edge; holds the request until pready is sampled
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) num_errors++;
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk_reg(rd_q, exp);
    endtask : rd

    function automatic logic [15:0] corr(input logic [15:0] raw);
        longint s;
        s = longint'($signed(raw)) + longint'($signed(ofs));
        s = (s * longint'(gn)) >>> 15;
        if (s > 32767 || s < -32768) sat_exp = 1'b1;
        if (s > 32767) s = 32767;
        if (s < -32768) s = -32768;
        return 16'(s >>> 1);
    endfunction : corr

    // Pulse one conversion; a write is expected only when the channel should take it
    task automatic conv(input logic [15:0] raw, input logic push, input logic [31:0] a);
        int n;
        logic [15:0] d;
        d = corr(raw);
        conv_done <= 1'b1;
        conv_result <= raw;
        if (push) exp_q.push_back({a, d});
        @(posedge clk);
        conv_done <= 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n == 100) num_errors++;
        repeat (4) @(posedge clk);
    endtask : conv

    always @(posedge clk) begin
        if (rstn && ram_wr.wr_valid === 1'b1 && ram_wr_ready) begin
            exp_w = 'x;
            if (exp_q.size() != 0) exp_w = exp_q.pop_front();
            chk_wr({ram_wr.wr_addr, ram_wr.wr_data}, exp_w);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        void'($urandom(73130));
        {rstn, psel, penable, pwrite, conv_done, slow, sat_exp} = '0;
        {paddr, pwdata, conv_result} = '0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(acd_pkg::OFS_OFFSET, 32'h0);
        rd(acd_pkg::OFS_GAIN, 32'h8000);
        rd(8'h20, 32'h0);
        chk_reg({31'h0, err_q}, 32'h1);
        $display("test reset_values done");
        ofs = 16'hfff0;
        gn = 16'h4000 | 16'($urandom % 32768);
        wr(acd_pkg::OFS_OFFSET, {16'h0, ofs});
        wr(acd_pkg::OFS_GAIN, {16'h0, gn});
        wr(acd_pkg::OFS_BUF_START, 32'h200);
        wr(acd_pkg::OFS_BUF_COUNT, 32'h4);
        wr(acd_pkg::OFS_CHAN_CFG, 32'h10);
        wr(acd_pkg::OFS_CHAN_CFG, 32'h2);
        wr(acd_pkg::OFS_CONV_CFG, 32'h3);
        chk_reg({31'h0, neg_buffer_select}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            conv(16'($urandom), 1'b1, 32'h200 + 32'(2 * i));
            if (i == 1) rd(acd_pkg::OFS_FLAGS, {28'h0, 3'b001, sat_exp});
        end
        rd(acd_pkg::OFS_CUR_ADDR, 32'h206);
        rd(acd_pkg::OFS_FLAGS, {28'h0, 3'b011, sat_exp});
        conv(16'($urandom), 1'b0, 32'h0);
        rd(acd_pkg::OFS_FLAGS, {28'h0, 3'b111, sat_exp});
        wr(acd_pkg::OFS_FLAGS, 32'hf);
        sat_exp = 1'b0;
        rd(acd_pkg::OFS_FLAGS, 32'h0);
        $display("test linear done");
        ofs = 16'h0;
        gn = 16'hffff;
        slow <= 1'b1;
        wr(acd_pkg::OFS_OFFSET, 32'h0);
        wr(acd_pkg::OFS_GAIN, 32'hffff);
        wr(acd_pkg::OFS_BUF_START, 32'h300);
        wr(acd_pkg::OFS_BUF_COUNT, 32'h2);
        wr(acd_pkg::OFS_CHAN_CFG, 32'h10);
        wr(acd_pkg::OFS_CHAN_CFG, 32'h3);
        wr(acd_pkg::OFS_CONV_CFG, 32'h1);
        chk_reg({31'h0, neg_buffer_select}, 32'h0);
        conv(16'h7000, 1'b1, 32'h300);
        conv(16'h9000, 1'b1, 32'h302);
        for (int i = 0; i < 3; i++) begin
            conv(16'($urandom), 1'b1, 32'h300 + 32'(2 * (i % 2)));
        end
        rd(acd_pkg::OFS_CUR_ADDR, 32'h302);
        rd(acd_pkg::OFS_FLAGS, {28'h0, 3'b011, 1'b1});
        wr(acd_pkg::OFS_CONV_CFG, 32'h0);
        chk_reg({31'h0, conv_enable}, 32'h0);
        conv(16'($urandom), 1'b0, 32'h0);
        $display("test wrap_saturation done");
        test_done();
    end
endmodule : acd_top_tb
`default_nettype wire
